// File: hdl/bbdc_map.svh
`ifndef BBDC_MAP_SVH
`define BBDC_MAP_SVH
// timing
`define BBDC_CLK_NS        50
`define BBDC_SS_TIME_NS    3600000
`define BBDC_SYNC_WIN_NS   10000
`define BBDC_DITH_STEP_NS  40000
`define BBDC_TRIM_MAX      4'sh7
// bus target addresses by address-select level
`define BBDC_ADDR_SEL_HIGH 7'h74
`define BBDC_ADDR_SEL_LOW  7'h75
// register offsets
`define BBDC_REG_VREF_LO   'h0
`define BBDC_REG_VREF_HI   'h1
`define BBDC_REG_ILIM      'h2
`define BBDC_REG_FBK       'h4
`define BBDC_REG_DROOP     'h5
`define BBDC_REG_CTRL      'h6
`define BBDC_REG_STATUS    3'h7
// field positions inside their byte
`define BBDC_ILIM_EN_BIT   'h7
`define BBDC_FBK_SRC_BIT   'h7
`define BBDC_OE_BIT        'h7
`define BBDC_DRAIN_BIT     'h4
// reset values and writable masks, byte n at [8n+7:8n]
`define BBDC_REG_RESET     64'h00000003_00e40000
`define BBDC_REG_MASK      64'h00900783_00ff07ff
// synchronised pin indices
`define BBDC_P_SCL         0
`define BBDC_P_SDA         1
`define BBDC_P_VIN         2
`define BBDC_P_EN_ON       3
`define BBDC_P_EN_OFF      4
`define BBDC_P_DLO         5
`define BBDC_P_DHI         6
`define BBDC_P_DCLK        7
`define BBDC_P_VLOW        8
`define BBDC_P_ASEL        9
`define BBDC_NPINS         10
// synchroniser reset levels: bus lines, supply and enable idle high
`define BBDC_PIN_IDLE      10'h00f
`endif

// File: hdl/bbdc_pkg.sv
package bbdc_pkg;
  typedef enum logic [3:0] {
    I2C_IDLE = 4'h0, I2C_ADDR = 4'h1, I2C_AACK = 4'h2, I2C_REG = 4'h3,
    I2C_RACK = 4'h4, I2C_WDAT = 4'h5, I2C_DACK = 4'h6, I2C_RDAT = 4'h7,
    I2C_MACK = 4'h8
  } bbdc_i2c_t;
  typedef struct packed {
    logic        oe;
    logic        discharge_bit;
    logic        feedback_source_bit;
    logic [1:0]  internal_ratio_field;
    logic [2:0]  droop_comp_field;
    logic        ilim_en;
    logic [6:0]  ilim_code;
    logic [10:0] vref_code;
  } bbdc_cfg_t;
endpackage : bbdc_pkg

// File: hdl/bbdc_core.sv
`timescale 1ns/1ns
`include "bbdc_map.svh"
// How it works
// - bus commands are taken only with input and enable pin above lockout
// - output enable ramps the reference from zero to the code in 3.6 ms
// - enable pin below 0.4 V shuts the device down completely
// - shutdown returns every register to its default
// - output enable low stops switching, bus stays alive
// - output enable low with discharge bit sinks output until under 0.8 V
// - dither pin below 0.4 V or above 1.2 V turns dithering off
// - an external sync clock on the dither pin turns dithering off
// - active dithering sweeps the frequency over plus and minus 7 percent
// - an 11-bit reference code spans offsets 00h and 01h
// - feedback source bit picks internal ratio or external divider
// - two-bit ratio field picks one of four internal feedback ratios
// - three-bit droop field sets cable compensation, zero after reset
// - current limit code is a sense voltage in 0.5 mV steps
// - clearing the current limit enable bit disables limiting
// - bus target at 74h or 75h by address pin, registers 00h to 07h
module bbdc_core
  import bbdc_pkg::*;
#(
  parameter int unsigned SS_CYCLES = `BBDC_SS_TIME_NS / `BBDC_CLK_NS
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // serial bus pins
  input  wire logic              scl,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe,
  // comparator and pin levels
  input  wire logic              vin_above_lockout,
  input  wire logic              enable_lockout_pin_on,
  input  wire logic              enable_lockout_pin_off,
  input  wire logic              dither_sync_pin_low,
  input  wire logic              dither_sync_pin_high,
  input  wire logic              dither_sync_pin_clk,
  input  wire logic              vout_below_0v8,
  input  wire logic              addr_select,
  // converter control
  output bbdc_cfg_t              cfg,
  output logic [10:0]            vref_ramp,
  output logic                   switch_en,
  output logic                   discharge_en,
  output logic                   dither_en,
  output logic signed [3:0]      freq_trim_pct
);
  localparam logic [63:0] REG_RESET = `BBDC_REG_RESET;
  localparam logic [63:0] REG_MASK  = `BBDC_REG_MASK;
  localparam int SYNC_CYC = `BBDC_SYNC_WIN_NS / `BBDC_CLK_NS;
  localparam int DITH_CYC = `BBDC_DITH_STEP_NS / `BBDC_CLK_NS;

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [`BBDC_NPINS-1:0] pin_raw, pin_m, pin_s, pin_q;
  assign pin_raw = {addr_select, vout_below_0v8, dither_sync_pin_clk,
                    dither_sync_pin_high, dither_sync_pin_low,
                    enable_lockout_pin_off, enable_lockout_pin_on,
                    vin_above_lockout, sda_in, scl};
  // two flops per pin, then one delay stage for edges; idle levels on reset
  // so that no false sync edge is seen once reset lets go
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_m <= `BBDC_PIN_IDLE;
      pin_s <= `BBDC_PIN_IDLE;
      pin_q <= `BBDC_PIN_IDLE;
    end else begin
      pin_m <= pin_raw;
      pin_s <= pin_m;
      pin_q <= pin_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // power state and bus conditions
  wire shut      = pin_s[`BBDC_P_EN_OFF] | ~pin_s[`BBDC_P_VIN];
  wire cmd_ready = ~shut & pin_s[`BBDC_P_EN_ON];
  wire scl_s     = pin_s[`BBDC_P_SCL];
  wire sda_s     = pin_s[`BBDC_P_SDA];
  wire scl_rise  = scl_s & ~pin_q[`BBDC_P_SCL];
  wire scl_fall  = ~scl_s & pin_q[`BBDC_P_SCL];
  wire start_c   = scl_s & pin_q[`BBDC_P_SCL] & ~sda_s & pin_q[`BBDC_P_SDA];
  wire stop_c    = scl_s & pin_q[`BBDC_P_SCL] & sda_s & ~pin_q[`BBDC_P_SDA];
  wire [6:0] my_addr = pin_s[`BBDC_P_ASEL] ? `BBDC_ADDR_SEL_HIGH
                                           : `BBDC_ADDR_SEL_LOW;

  //////////////////////////////////////////////////////////////////////////
  // serial target state
  bbdc_i2c_t   state;
  logic [3:0]  cnt;
  logic [7:0]  shreg;
  logic        rd_mode;
  logic [2:0]  ptr;
  logic [63:0] regs;
  logic        ss_run, ss_done, sync_lock;
  wire  rx_state = (state == I2C_ADDR) | (state == I2C_REG) |
                   (state == I2C_WDAT);
  wire  addr_hit = (shreg[7:1] == my_addr);
  wire  byte_end = scl_fall & (cnt == 4'h8);
  wire  [7:0] status  = {4'h0, ss_run, ss_done, dither_en, sync_lock};
  wire  [7:0] rd_byte = (ptr == `BBDC_REG_STATUS) ? status
                        : regs[{ptr, 3'b000} +: 8];
  wire  [7:0] wmask   = REG_MASK[{ptr, 3'b000} +: 8];
  wire  [7:0] wr_byte = (shreg & wmask) | (regs[{ptr, 3'b000} +: 8] & ~wmask);
  wire  do_write = byte_end & (state == I2C_WDAT);

  // bit engine: sample on scl rise, drive sda on scl fall
  always_ff @(posedge clk_sys) begin
    if (rst || !cmd_ready) begin
      state   <= I2C_IDLE;
      cnt     <= 4'h0;
      shreg   <= 8'h00;
      rd_mode <= 1'b0;
      sda_oe  <= 1'b0;
    end else if (start_c) begin
      state  <= I2C_ADDR;
      cnt    <= 4'h0;
      sda_oe <= 1'b0;
    end else if (stop_c) begin
      state  <= I2C_IDLE;
      sda_oe <= 1'b0;
    end else if (scl_rise) begin
      if (rx_state) begin
        shreg <= {shreg[6:0], sda_s};
        cnt   <= 4'(cnt + 4'h1);
      end else if (state == I2C_RDAT) begin
        cnt <= 4'(cnt + 4'h1);
      end else if (state == I2C_MACK && sda_s) begin
        state <= I2C_IDLE;                    // controller nack ends a read
      end
    end else if (scl_fall) begin
      case (state)
        I2C_ADDR: if (cnt == 4'h8) begin
          if (addr_hit) begin
            state   <= I2C_AACK;
            sda_oe  <= 1'b1;
            rd_mode <= shreg[0];
          end else begin
            state <= I2C_IDLE;
          end
        end
        I2C_REG: if (cnt == 4'h8) begin
          state  <= I2C_RACK;
          sda_oe <= 1'b1;
        end
        I2C_WDAT: if (cnt == 4'h8) begin
          state  <= I2C_DACK;
          sda_oe <= 1'b1;
        end
        I2C_AACK, I2C_MACK: begin
          cnt <= 4'h0;
          if (rd_mode) begin
            state  <= I2C_RDAT;
            shreg  <= rd_byte;
            sda_oe <= ~rd_byte[7];
          end else begin
            state  <= I2C_REG;
            sda_oe <= 1'b0;
          end
        end
        I2C_RACK, I2C_DACK: begin
          state  <= I2C_WDAT;
          cnt    <= 4'h0;
          sda_oe <= 1'b0;
        end
        I2C_RDAT: if (cnt == 4'h8) begin
          state  <= I2C_MACK;
          sda_oe <= 1'b0;
        end else begin
          shreg  <= {shreg[6:0], 1'b0};
          sda_oe <= ~shreg[6];
        end
        default: ;
      endcase
    end
  end

  // open-drain data line only ever pulls low
  always_ff @(posedge clk_sys) begin
    sda_out <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // register file and pointer
  always_ff @(posedge clk_sys) begin
    if (rst || shut) begin
      regs <= REG_RESET;
      ptr  <= 3'h0;
    end else if (byte_end && state == I2C_REG) begin
      ptr <= shreg[2:0];
    end else if (do_write) begin
      regs[{ptr, 3'b000} +: 8] <= wr_byte;
      ptr <= 3'(ptr + 3'h1);                   // auto-increment for bursts
    end else if (byte_end && state == I2C_RDAT) begin
      ptr <= 3'(ptr + 3'h1);
    end
  end

  // field decode into the control word
  bbdc_cfg_t next_cfg;
  assign next_cfg.oe = regs[`BBDC_REG_CTRL*8 + `BBDC_OE_BIT];
  assign next_cfg.discharge_bit = regs[`BBDC_REG_CTRL*8 + `BBDC_DRAIN_BIT];
  assign next_cfg.feedback_source_bit =
           regs[`BBDC_REG_FBK*8 + `BBDC_FBK_SRC_BIT];
  assign next_cfg.internal_ratio_field =
           regs[`BBDC_REG_FBK*8 +: 2];
  assign next_cfg.droop_comp_field =
           regs[`BBDC_REG_DROOP*8 +: 3];
  assign next_cfg.ilim_en =
           regs[`BBDC_REG_ILIM*8 + `BBDC_ILIM_EN_BIT];
  assign next_cfg.ilim_code = regs[`BBDC_REG_ILIM*8 +: 7];
  assign next_cfg.vref_code = regs[10:0];

  always_ff @(posedge clk_sys) begin
    if (rst) cfg <= bbdc_cfg_t'(0);
    else     cfg <= next_cfg;
  end

  //////////////////////////////////////////////////////////////////////////
  // soft start: rate-matched accumulator gives even steps
  logic [31:0] ss_cnt, ss_acc;
  wire  [31:0] acc_sum = ss_acc + {21'h0, cfg.vref_code};
  always_ff @(posedge clk_sys) begin
    if (rst || shut || !cfg.oe) begin
      ss_cnt    <= 32'h0;
      ss_acc    <= 32'h0;
      vref_ramp <= 11'h000;
      ss_run    <= 1'b0;
      ss_done   <= 1'b0;
    end else if (!ss_done) begin
      ss_cnt  <= ss_cnt + 32'h1;
      ss_run  <= (ss_cnt != SS_CYCLES - 1);
      ss_done <= (ss_cnt == SS_CYCLES - 1);
      if (acc_sum >= SS_CYCLES) begin
        ss_acc    <= acc_sum - SS_CYCLES;
        vref_ramp <= 11'(vref_ramp + 11'h001);
      end else begin
        ss_acc <= acc_sum;
      end
    end else begin
      vref_ramp <= cfg.vref_code;          // later code writes take effect
    end
  end

  // power stage enables
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      switch_en    <= 1'b0;
      discharge_en <= 1'b0;
    end else begin
      switch_en    <= cmd_ready & cfg.oe;
      discharge_en <= cmd_ready & ~cfg.oe & cfg.discharge_bit &
                      ~pin_s[`BBDC_P_VLOW];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sync detection and frequency dither
  logic [15:0] sync_tmr, dith_tmr;
  logic        trim_up;
  wire  dclk_edge = pin_s[`BBDC_P_DCLK] ^ pin_q[`BBDC_P_DCLK];
  wire  next_dith = cmd_ready & ~pin_s[`BBDC_P_DLO] & ~pin_s[`BBDC_P_DHI]
                    & ~sync_lock;
  assign sync_lock = (sync_tmr != 16'h0);
  always_ff @(posedge clk_sys) begin
    if (rst) sync_tmr <= 16'h0;
    else if (dclk_edge) sync_tmr <= 16'(SYNC_CYC);
    else if (sync_lock) sync_tmr <= 16'(sync_tmr - 16'h1);
  end

  always_ff @(posedge clk_sys) begin
    if (rst || !next_dith) begin
      dither_en     <= 1'b0;
      freq_trim_pct <= 4'sh0;
      dith_tmr      <= 16'h0;
      trim_up       <= 1'b1;
    end else begin
      dither_en <= 1'b1;
      dith_tmr  <= (dith_tmr == 16'(DITH_CYC - 1)) ? 16'h0
                   : 16'(dith_tmr + 16'h1);
      if (dith_tmr == 16'(DITH_CYC - 1)) begin
        freq_trim_pct <= trim_up ? freq_trim_pct + 4'sh1
                                 : freq_trim_pct - 4'sh1;
        if (trim_up && freq_trim_pct == `BBDC_TRIM_MAX - 4'sh1)
          trim_up <= 1'b0;
        if (!trim_up && freq_trim_pct == 4'sh1 - `BBDC_TRIM_MAX)
          trim_up <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  AST_UNREADY: assert property (@(posedge clk_sys) disable iff (rst)
    !cmd_ready |=> state == I2C_IDLE && !sda_oe)
    else $error("bus active while not ready");
  AST_SS_GO: assert property (@(posedge clk_sys) disable iff (rst)
    (cmd_ready && $rose(cfg.oe)) |=> vref_ramp == 11'h000 ##1 ss_run)
    else $error("soft start did not begin from zero");
  AST_SS_END: assert property (@(posedge clk_sys) disable iff (rst)
    ($rose(ss_done) && $stable(cfg.vref_code)) |-> vref_ramp == cfg.vref_code)
    else $error("ramp ended off target");
  AST_SHUTDN: assert property (@(posedge clk_sys) disable iff (rst)
    shut |=> !switch_en && !discharge_en && !sda_oe && !dither_en)
    else $error("outputs active in shutdown");
  AST_DEFAULT: assert property (@(posedge clk_sys) disable iff (rst)
    shut |=> regs == REG_RESET)
    else $error("registers not defaulted in shutdown");
  AST_OE_OFF: assert property (@(posedge clk_sys) disable iff (rst)
    !cfg.oe |=> !switch_en)
    else $error("switching with output enable low");
  AST_DRAIN: assert property (@(posedge clk_sys) disable iff (rst)
    (cmd_ready && !cfg.oe && cfg.discharge_bit && !pin_s[`BBDC_P_VLOW])
      |=> discharge_en)
    else $error("discharge not active");
  AST_PIN_WIN: assert property (@(posedge clk_sys) disable iff (rst)
    (pin_s[`BBDC_P_DLO] || pin_s[`BBDC_P_DHI]) |=> !dither_en &&
      freq_trim_pct == 4'sh0)
    else $error("dither active with pin out of window");
  AST_SYNC: assert property (@(posedge clk_sys) disable iff (rst)
    dclk_edge |=> sync_lock ##1 !dither_en)
    else $error("dither active with sync clock");
  AST_SPAN: assert property (@(posedge clk_sys) disable iff (rst)
    freq_trim_pct <= `BBDC_TRIM_MAX && freq_trim_pct >= -`BBDC_TRIM_MAX)
    else $error("dither beyond span");
  AST_ILIM: assert property (@(posedge clk_sys) disable iff (rst)
    !regs[`BBDC_REG_ILIM*8 + `BBDC_ILIM_EN_BIT] |=> !cfg.ilim_en)
    else $error("current limit enabled after clear");
  AST_ADDR: assert property (@(posedge clk_sys) disable iff (rst)
    (state == I2C_ADDR && byte_end && !start_c && !stop_c && cmd_ready &&
     !addr_hit) |=> state == I2C_IDLE && !sda_oe)
    else $error("acked foreign address");
  AST_MONO: assert property (@(posedge clk_sys) disable iff (rst)
    (ss_run && $past(ss_run)) |-> vref_ramp >= $past(vref_ramp) &&
      vref_ramp <= 11'($past(vref_ramp) + 11'h001))
    else $error("ramp not monotonic");
endmodule : bbdc_core

// File: sim/bbdc_i2c_ctl.sv
`timescale 1ns/1ns
module bbdc_i2c_ctl (
  // clock
  input  wire logic clk_sys,
  // resolved bus wire
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  // bus idles released, clock stands high outside frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // quarter bit, four quarters make 400 ns
  task automatic qtr;
    repeat (2) @(posedge clk_sys);
  endtask : qtr
  // start or repeated start: data falls while clock high
  task automatic start;
    sda_low <= 1'b0;
    qtr();
    scl <= 1'b1;
    qtr();
    sda_low <= 1'b1;
    qtr();
    scl <= 1'b0;
    qtr();
  endtask : start
  // stop: data rises while clock high
  task automatic stop;
    sda_low <= 1'b1;
    qtr();
    scl <= 1'b1;
    qtr();
    sda_low <= 1'b0;
    qtr();
  endtask : stop
  // one bit, data changed only while clock low, sampled mid-high
  task automatic bit_xfer(input logic b, output logic r);
    sda_low <= ~b;
    qtr();
    scl <= 1'b1;
    qtr();
    r = sda;
    qtr();
    scl <= 1'b0;
    qtr();
  endtask : bit_xfer
  // byte out msb first, returns the target's acknowledge
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask : wr_byte
  // byte in msb first, last byte answered with not-acknowledge
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(last, r);
  endtask : rd_byte
endmodule : bbdc_i2c_ctl

// File: sim/testbench.sv
`timescale 1ns/1ns
`include "bbdc_map.svh"
module testbench;
  import bbdc_pkg::*;
  localparam int unsigned SS    = 4096;
  localparam logic [6:0]  ADR_H = `BBDC_ADDR_SEL_HIGH;
  localparam logic [6:0]  ADR_L = `BBDC_ADDR_SEL_LOW;
  logic clk_sys = 1'b0, rst = 1'b1, vin = 1'b1, en_on = 1'b1, en_off = 1'b0;
  logic dlo = 1'b0, dhi = 1'b0, dclk = 1'b0, vlow = 1'b0, asel = 1'b1;
  logic scl, sda_low, sda_out, sda_oe, switch_en, discharge_en, dither_en;
  bbdc_cfg_t          cfg;
  logic [10:0]        vref_ramp, code, prev;
  logic signed [3:0]  freq_trim_pct, tmin, tmax;
  logic [31:0]        seed = 32'h1e;
  logic [7:0]         v [0:5];
  logic [7:0]         d;
  logic               ok, step_ok;
  int                 fails = 0, tests_run = 0, n;
  // open-drain wire with pull-up
  wire sda = ~((sda_oe & ~sda_out) | sda_low);
  // system clock 50 ns
  always #25 clk_sys = ~clk_sys;
  bbdc_core #(.SS_CYCLES(SS)) i_bbdc_core (
    .clk_sys(clk_sys), .rst(rst), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .vin_above_lockout(vin),
    .enable_lockout_pin_on(en_on), .enable_lockout_pin_off(en_off),
    .dither_sync_pin_low(dlo), .dither_sync_pin_high(dhi),
    .dither_sync_pin_clk(dclk), .vout_below_0v8(vlow), .addr_select(asel),
    .cfg(cfg), .vref_ramp(vref_ramp), .switch_en(switch_en),
    .discharge_en(discharge_en), .dither_en(dither_en),
    .freq_trim_pct(freq_trim_pct));
  bbdc_i2c_ctl i_bbdc_i2c_ctl (.clk_sys(clk_sys), .sda(sda), .scl(scl),
    .sda_low(sda_low));
  ////////////////////////////////////////////////////////////////////////////
  // random source and expectations
  function automatic logic [31:0] xs;
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  function automatic logic [7:0] exp_reg(input int a, input logic [7:0] x);
    logic [63:0] m;
    m = `BBDC_REG_MASK;
    return m[8*a +: 8] & x;
  endfunction : exp_reg
  function automatic logic [7:0] def_reg(input int a);
    logic [63:0] m;
    m = `BBDC_REG_RESET;
    return m[8*a +: 8];
  endfunction : def_reg
  ////////////////////////////////////////////////////////////////////////////
  // checking, bus cycles and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus_wr(input logic [6:0] dev, input logic [7:0] a,
                        input logic [7:0] x, output logic ack);
    logic k1, k2, k3;
    i_bbdc_i2c_ctl.start();
    i_bbdc_i2c_ctl.wr_byte({dev, 1'b0}, k1);
    i_bbdc_i2c_ctl.wr_byte(a, k2);
    i_bbdc_i2c_ctl.wr_byte(x, k3);
    i_bbdc_i2c_ctl.stop();
    ack = k1 & k2 & k3;
  endtask : bus_wr
  task automatic bus_rd(input logic [6:0] dev, input logic [7:0] a,
                        output logic [7:0] x, output logic ack);
    logic k1, k2, k3;
    i_bbdc_i2c_ctl.start();
    i_bbdc_i2c_ctl.wr_byte({dev, 1'b0}, k1);
    i_bbdc_i2c_ctl.wr_byte(a, k2);
    i_bbdc_i2c_ctl.start();
    i_bbdc_i2c_ctl.wr_byte({dev, 1'b1}, k3);
    i_bbdc_i2c_ctl.rd_byte(1'b1, x);
    i_bbdc_i2c_ctl.stop();
    ack = k1 & k2 & k3;
  endtask : bus_rd
  task automatic reg_chk(input int a, input logic [7:0] e);
    logic [7:0] x;
    logic       k;
    bus_rd(ADR_H, a[7:0], x, k);
    chk(k, 1'b1);
    chk(x, e);
  endtask : reg_chk
  task automatic summarize;
    $display("checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  // watchdog, run needs roughly 24000 cycles
  initial begin
    repeat (90000) @(posedge clk_sys);
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    summarize();
  end
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (6) @(posedge clk_sys);
    // dither sweep from reset, pins in the dithering window
    tmin = 4'sh0;
    tmax = 4'sh0;
    repeat (6000) begin
      @(posedge clk_sys);
      #1;
      if (freq_trim_pct > tmax) tmax = freq_trim_pct;
      if (freq_trim_pct < tmin) tmin = freq_trim_pct;
    end
    chk(dither_en, 1'b1);
    chk(tmax === 4'sh7 || tmin === -4'sh7, 1'b1);
    chk(tmax <= 4'sh7 && tmin >= -4'sh7, 1'b1);
    for (int m = 1; m < 4; m++) begin
      dlo <= (m == 1);
      dhi <= (m == 2);
      repeat (15) begin
        repeat (4) @(posedge clk_sys);
        if (m == 3) dclk <= ~dclk;
      end
      chk(dither_en, 1'b0);
    end
    dlo <= 1'b0;
    dhi <= 1'b0;
    for (int a = 0; a < 7; a++) reg_chk(a, def_reg(a));
    chk(cfg.droop_comp_field, 3'h0);
    // address pin low moves the target address
    asel <= 1'b0;
    repeat (4) @(posedge clk_sys);
    bus_rd(ADR_L, 8'h00, d, ok);
    chk(ok, 1'b1);
    bus_rd(ADR_H, 8'h00, d, ok);
    chk(ok, 1'b0);
    asel <= 1'b1;
    repeat (4) @(posedge clk_sys);
    // random configuration, reserved byte and bits must read back zero
    repeat (2) for (int a = 0; a < 6; a++) begin
      v[a] = 8'(xs());
      bus_wr(ADR_H, a[7:0], v[a], ok);
      chk(ok, 1'b1);
      reg_chk(a, exp_reg(a, v[a]));
    end
    chk(cfg.vref_code, {v[1][2:0], v[0]});
    chk(cfg.ilim_en, v[2][7]);
    chk(cfg.ilim_code, v[2][6:0]);
    chk(cfg.feedback_source_bit, v[4][7]);
    chk(cfg.internal_ratio_field, v[4][1:0]);
    chk(cfg.droop_comp_field, v[5][2:0]);
    // soft start to a high code, configured before output enable
    bus_wr(ADR_H, 8'h01, 8'h07, ok);
    code = {3'h7, v[0]};
    chk(vref_ramp, 11'h000);
    step_ok = 1'b1;
    prev = 11'h000;
    n = 0;
    fork
      bus_wr(ADR_H, 8'h06, 8'h80, ok);
      begin
        wait (cfg.oe === 1'b1);
        while (vref_ramp !== code && n < SS + 8) begin
          @(posedge clk_sys);
          #1;
          step_ok &= (vref_ramp >= prev) && (vref_ramp <= prev + 11'h001);
          prev = vref_ramp;
          n++;
        end
      end
    join
    chk(step_ok, 1'b1);
    chk(n >= SS - 3 && n <= SS + 3, 1'b1);
    chk(switch_en, 1'b1);
    chk(discharge_en, 1'b0);
    reg_chk(7, 8'h06);
    // output enable cleared with discharge requested
    bus_wr(ADR_H, 8'h06, 8'h10, ok);
    repeat (4) @(posedge clk_sys);
    chk(switch_en, 1'b0);
    chk(discharge_en, 1'b1);
    chk({cfg.oe, cfg.discharge_bit}, 2'b01);
    vlow <= 1'b1;
    repeat (5) @(posedge clk_sys);
    chk(discharge_en, 1'b0);
    reg_chk(6, 8'h10);
    vlow <= 1'b0;
    // shutdown while running clears everything
    bus_wr(ADR_H, 8'h06, 8'h80, ok);
    en_off <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk(switch_en, 1'b0);
    chk(vref_ramp, 11'h000);
    en_off <= 1'b0;
    repeat (6) @(posedge clk_sys);
    for (int a = 0; a < 7; a++) reg_chk(a, def_reg(a));
    // commands refused below lockout or without enable
    for (int m = 0; m < 2; m++) begin
      vin <= (m != 0);
      en_on <= (m == 0);
      repeat (4) @(posedge clk_sys);
      bus_wr(ADR_H, 8'h00, 8'h55, ok);
      chk(ok, 1'b0);
      vin <= 1'b1;
      en_on <= 1'b1;
      repeat (6) @(posedge clk_sys);
      reg_chk(0, 8'h00);
    end
    summarize();
  end
endmodule : testbench
